// file: design/ccsr_pkg.sv
// shared constants, codes and state layout for the charger register block
package ccsr_pkg;
	// register offsets
	localparam logic [7:0] CCSR_OFS_CTRL = 8'h07;
	localparam logic [7:0] CCSR_OFS_STAT = 8'h08;
	localparam logic [7:0] CCSR_OFS_FAULT = 8'h09;
	// control field positions
	localparam int CCSR_B_DETECT = 7;
	localparam int CCSR_B_HALF = 6;
	localparam int CCSR_B_SWOFF = 5;
	localparam int CCSR_B_WARMSEL = 4;
	localparam int CCSR_B_SWDLY = 3;
	localparam int CCSR_B_SWRST = 2;
	localparam int CCSR_B_TRACK = 0;
	// control value after reset and the bits that survive watchdog expiry
	localparam logic [7:0] CCSR_CTRL_RST = 8'h4c;
	localparam logic [7:0] CCSR_WD_KEEP = 8'h2b;
	// clock and times
	localparam int CCSR_CLK_HZ = 10_000_000;
	localparam int CCSR_SWOFF_DLY_S = 10;
	localparam int CCSR_WD_BASE_S = 40;
	localparam int CCSR_SWOFF_DLY_CYC = CCSR_SWOFF_DLY_S * CCSR_CLK_HZ;
	localparam int CCSR_WD_BASE_CYC = CCSR_WD_BASE_S * CCSR_CLK_HZ;
	localparam int CCSR_CNT_W = 32;
	// voltages in mV
	localparam logic [13:0] CCSR_WARM_CAP_MV = 14'h1004;
	localparam logic [13:0] CCSR_TRK1_MV = 14'h00c8;
	localparam logic [13:0] CCSR_TRK2_MV = 14'h00fa;
	localparam logic [13:0] CCSR_TRK3_MV = 14'h012c;
	// input source codes
	localparam logic [2:0] CCSR_SRC_NONE = 3'h0;
	localparam logic [2:0] CCSR_SRC_SDP = 3'h1;
	localparam logic [2:0] CCSR_SRC_DCP = 3'h3;
	localparam logic [2:0] CCSR_SRC_OTG = 3'h7;
	// charge phase codes
	localparam logic [1:0] CCSR_PH_IDLE = 2'h0;
	localparam logic [1:0] CCSR_PH_PRE = 2'h1;
	localparam logic [1:0] CCSR_PH_FAST = 2'h2;
	localparam logic [1:0] CCSR_PH_DONE = 2'h3;
	// charge fault codes
	localparam logic [1:0] CCSR_CF_OK = 2'h0;
	localparam logic [1:0] CCSR_CF_INPUT = 2'h1;
	localparam logic [1:0] CCSR_CF_TSD = 2'h2;
	localparam logic [1:0] CCSR_CF_TIMER = 2'h3;
	// thermistor zone codes
	localparam logic [2:0] CCSR_TZ_NORMAL = 3'h0;
	localparam logic [2:0] CCSR_TZ_WARM = 3'h2;
	localparam logic [2:0] CCSR_TZ_COOL = 3'h3;
	localparam logic [2:0] CCSR_TZ_COLD = 3'h5;
	localparam logic [2:0] CCSR_TZ_HOT = 3'h6;
	// thermistor zone as judged by the analog side
	typedef enum logic [2:0] {ZONE_NORMAL, ZONE_WARM, ZONE_COOL, ZONE_COLD, ZONE_HOT} ccsr_zone_e;
	// whole state of the block
	typedef struct packed {
		logic [7:0] ctrl;
		logic detect_busy;
		logic detect_start;
		logic [CCSR_CNT_W-1:0] off_cnt;
		logic switch_open;
		logic [CCSR_CNT_W-1:0] wd_cnt;
		logic wd_fault;
		logic wd_expired;
		logic half_phase;
		logic safety_tick;
		logic safety_reset;
		logic reset_done;
		logic [13:0] vchg_target;
		logic [13:0] vin_limit;
		logic [7:0] rdata;
		logic rvalid;
		logic [1:0] psel_sync;
		logic swrst_en;
	} ccsr_state_s;
endpackage

// file: design/ccsr_regs.sv
// charger control and status register block
`timescale 1ns/1ps
module ccsr_regs
	import ccsr_pkg::*;
#(
	parameter bit PSEL_VARIANT = 1'b0, // 1: source select pin part
	parameter int SWOFF_DLY_CYCLES = CCSR_SWOFF_DLY_CYC, // switch-off delay
	parameter int WD_BASE_CYCLES = CCSR_WD_BASE_CYC // shortest watchdog period
) (
	input wire logic sys_clk, // core clock
	input wire logic srst, // sync reset, active high
	input wire logic [7:0] bus_addr, // register offset
	input wire logic bus_wr, // write strobe
	input wire logic [7:0] bus_wdata, // write data
	input wire logic bus_rd, // read strobe
	output logic [7:0] bus_rdata, // read data
	output logic bus_rvalid, // read data valid pulse
	input wire logic defaults_cmd, // register-defaults command pulse
	input wire logic [1:0] wd_period, // watchdog period field
	input wire logic detect_done, // data-line detection finished
	input wire logic [2:0] detected_type, // detection result code
	input wire logic psel_pin, // source select pin, async
	input wire logic vbus_present, // input attached
	input wire logic otg_active, // boost output running
	input wire logic boost_mode, // converter in boost
	input wire logic in_vlimit, // input voltage limiting
	input wire logic in_ilimit, // input current limiting
	input wire logic thermal_reg, // thermal current reduction
	input wire ccsr_zone_e zone, // thermistor zone
	input wire logic safety_tick_in, // safety timer base tick
	input wire logic charging, // charger active
	input wire logic precharge, // below precharge threshold
	input wire logic terminated, // charge terminated
	input wire logic power_good, // input power judged good
	input wire logic below_min_sys, // battery below system floor
	input wire logic boost_fault, // boost cannot start or run
	input wire logic input_fault, // input overvoltage or too low
	input wire logic thermal_shutdown, // thermal shutdown
	input wire logic safety_expired, // safety timer expired
	input wire logic bat_ovp, // battery overvoltage
	input wire logic [13:0] charge_voltage_target_mv, // programmed charge voltage
	input wire logic [13:0] input_voltage_limit_mv, // programmed input limit
	input wire logic [13:0] vbat_mv, // battery voltage
	output logic detect_start, // start detection pulse
	output logic switch_open, // battery switch opened
	output logic switch_reset_en, // switch reset function enable
	output logic safety_tick, // safety timer advance pulse
	output logic safety_reset, // safety timer reset pulse
	output logic defaults_done, // defaults restore done pulse
	output logic wd_expired, // watchdog expiry pulse
	output logic [13:0] vchg_target, // effective charge voltage
	output logic [13:0] vin_limit // effective input voltage limit
);

	ccsr_state_s st; // registered state
	ccsr_state_s next_st; // next state
	localparam ccsr_state_s ST_RST = '{ctrl: CCSR_CTRL_RST, swrst_en: 1'b1, default: '0};

	logic [7:0] stat_byte; // live source and charge status
	logic [7:0] fault_byte; // live fault status
	logic [2:0] src_code; // input source field
	logic [1:0] phase_code; // charge phase field
	logic [1:0] cfault_code; // charge fault field
	logic [2:0] zone_code; // thermistor field
	logic [13:0] track_ofs; // tracking offset
	logic [13:0] track_mv; // battery plus offset
	logic [CCSR_CNT_W-1:0] wd_limit; // selected watchdog count
	logic slow; // safety timer at half rate
	logic host_access; // any register access
	logic wr_ctrl; // write to control register

	// input source field, per variant
	always_comb begin
		if (otg_active) begin
			src_code = CCSR_SRC_OTG;
		end else if (!vbus_present) begin
			src_code = CCSR_SRC_NONE;
		end else if (PSEL_VARIANT) begin
			src_code = st.psel_sync[1] ? CCSR_SRC_SDP : CCSR_SRC_DCP;
		end else begin
			src_code = detected_type;
		end
	end

	// charge phase and fault codes
	always_comb begin
		if (!charging && !terminated) begin
			phase_code = CCSR_PH_IDLE;
		end else if (terminated) begin
			phase_code = CCSR_PH_DONE;
		end else if (precharge) begin
			phase_code = CCSR_PH_PRE;
		end else begin
			phase_code = CCSR_PH_FAST;
		end
		if (input_fault) begin
			cfault_code = CCSR_CF_INPUT;
		end else if (thermal_shutdown) begin
			cfault_code = CCSR_CF_TSD;
		end else if (safety_expired) begin
			cfault_code = CCSR_CF_TIMER;
		end else begin
			cfault_code = CCSR_CF_OK;
		end
	end

	// thermistor zone code, boost hides warm and cool
	always_comb begin
		unique case (zone)
			ZONE_NORMAL: zone_code = CCSR_TZ_NORMAL;
			ZONE_WARM: zone_code = boost_mode ? CCSR_TZ_NORMAL : CCSR_TZ_WARM;
			ZONE_COOL: zone_code = boost_mode ? CCSR_TZ_NORMAL : CCSR_TZ_COOL;
			ZONE_COLD: zone_code = CCSR_TZ_COLD;
			ZONE_HOT: zone_code = CCSR_TZ_HOT;
			default: zone_code = CCSR_TZ_NORMAL; // illegal zone input
		endcase
	end

	// live status bytes
	always_comb begin
		stat_byte = {src_code, phase_code, power_good, thermal_reg, below_min_sys};
		fault_byte = {st.wd_fault, boost_fault, cfault_code, bat_ovp, zone_code};
	end

	// tracking offset and watchdog period
	always_comb begin
		unique case (st.ctrl[CCSR_B_TRACK +: 2])
			2'h0: track_ofs = '0;
			2'h1: track_ofs = CCSR_TRK1_MV;
			2'h2: track_ofs = CCSR_TRK2_MV;
			2'h3: track_ofs = CCSR_TRK3_MV;
		endcase
		track_mv = vbat_mv + track_ofs;
		unique case (wd_period)
			2'h0: wd_limit = '0;
			2'h1: wd_limit = CCSR_CNT_W'(WD_BASE_CYCLES);
			2'h2: wd_limit = CCSR_CNT_W'(WD_BASE_CYCLES) << 1;
			2'h3: wd_limit = CCSR_CNT_W'(WD_BASE_CYCLES) << 2;
		endcase
	end

	// helper terms
	always_comb begin
		slow = st.ctrl[CCSR_B_HALF] && (in_vlimit || in_ilimit || zone == ZONE_COOL || thermal_reg);
		host_access = bus_wr || bus_rd;
		wr_ctrl = bus_wr && (bus_addr == CCSR_OFS_CTRL);
	end

	// next state
	always_comb begin
		next_st = st;
		next_st.psel_sync = {st.psel_sync[0], psel_pin};
		next_st.detect_start = 1'b0;
		next_st.wd_expired = 1'b0;
		next_st.safety_reset = 1'b0;
		next_st.reset_done = 1'b0;
		next_st.rvalid = 1'b0;
		next_st.safety_tick = 1'b0;
		// control register write, detect bit is a trigger when PSEL_VARIANT is 0
		if (wr_ctrl) begin
			next_st.ctrl = bus_wdata & ~(8'h1 << CCSR_B_DETECT);
			if (bus_wdata[CCSR_B_DETECT] && !PSEL_VARIANT) begin
				next_st.detect_busy = 1'b1;
				next_st.detect_start = 1'b1;
			end
		end
		if (detect_done && !next_st.detect_start) begin
			next_st.detect_busy = 1'b0;
		end
		// safety timer rate
		if (safety_tick_in) begin
			if (slow) begin
				next_st.half_phase = ~st.half_phase;
				next_st.safety_tick = st.half_phase;
			end else begin
				next_st.half_phase = 1'b0;
				next_st.safety_tick = 1'b1;
			end
		end
		// battery switch off, immediate or delayed
		if (!st.ctrl[CCSR_B_SWOFF]) begin
			next_st.switch_open = 1'b0;
			next_st.off_cnt = '0;
		end else if (!st.ctrl[CCSR_B_SWDLY]) begin
			next_st.switch_open = 1'b1;
		end else if (st.off_cnt >= CCSR_CNT_W'(SWOFF_DLY_CYCLES - 1)) begin
			next_st.switch_open = 1'b1;
		end else begin
			next_st.off_cnt = st.off_cnt + 1'b1;
		end
		next_st.swrst_en = st.ctrl[CCSR_B_SWRST];
		// effective charge voltage target
		if (zone == ZONE_WARM && !st.ctrl[CCSR_B_WARMSEL] && charge_voltage_target_mv > CCSR_WARM_CAP_MV) begin
			next_st.vchg_target = CCSR_WARM_CAP_MV;
		end else begin
			next_st.vchg_target = charge_voltage_target_mv;
		end
		// effective input voltage limit
		if (st.ctrl[CCSR_B_TRACK +: 2] != 2'h0 && track_mv > input_voltage_limit_mv) begin
			next_st.vin_limit = track_mv;
		end else begin
			next_st.vin_limit = input_voltage_limit_mv;
		end
		// register read, live status captured now
		if (bus_rd) begin
			next_st.rvalid = 1'b1;
			unique case (bus_addr)
				CCSR_OFS_CTRL: next_st.rdata = {PSEL_VARIANT ? st.psel_sync[1] : st.detect_busy,
					st.ctrl[6:0]};
				CCSR_OFS_STAT: next_st.rdata = stat_byte;
				CCSR_OFS_FAULT: next_st.rdata = fault_byte;
				default: next_st.rdata = 8'h00; // unmapped reads zero
			endcase
			if (bus_addr == CCSR_OFS_FAULT) begin
				next_st.wd_fault = 1'b0; // fault clears on read
			end
		end
		// watchdog, kicked by host traffic
		if (wd_period == 2'h0 || host_access) begin
			next_st.wd_cnt = '0;
		end else if (st.wd_cnt >= wd_limit - 1'b1) begin
			next_st.wd_cnt = '0;
			next_st.wd_expired = 1'b1;
			next_st.wd_fault = 1'b1;
			next_st.ctrl = (next_st.ctrl & CCSR_WD_KEEP) | (CCSR_CTRL_RST & ~CCSR_WD_KEEP);
			next_st.detect_busy = 1'b0;
		end else begin
			next_st.wd_cnt = st.wd_cnt + 1'b1;
		end
		// defaults command wins over control writes and the watchdog, but not the expiry and fault flags or the detect start pulse
		if (defaults_cmd) begin
			next_st.ctrl = CCSR_CTRL_RST;
			next_st.detect_busy = 1'b0;
			next_st.off_cnt = '0;
			next_st.switch_open = 1'b0;
			next_st.wd_cnt = '0;
			next_st.half_phase = 1'b0;
			next_st.safety_tick = 1'b0;
			next_st.safety_reset = 1'b1;
			next_st.reset_done = 1'b1;
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state flops
	assign bus_rdata = st.rdata;
	assign bus_rvalid = st.rvalid;
	assign detect_start = st.detect_start;
	assign switch_open = st.switch_open;
	assign switch_reset_en = st.swrst_en;
	assign safety_tick = st.safety_tick;
	assign safety_reset = st.safety_reset;
	assign defaults_done = st.reset_done;
	assign wd_expired = st.wd_expired;
	assign vchg_target = st.vchg_target;
	assign vin_limit = st.vin_limit;

endmodule // ccsr_regs

// file: sim/ccsr_host.sv
// host-side model that drives the byte register port
`timescale 1ns/1ps
module ccsr_host (
	input wire logic sys_clk, // core clock
	output logic [7:0] bus_addr, // register offset
	output logic bus_wr, // write strobe
	output logic [7:0] bus_wdata, // write data
	output logic bus_rd, // read strobe
	input wire logic [7:0] bus_rdata, // read data
	input wire logic bus_rvalid // read data valid
);
	// idle bus at time zero
	initial begin
		bus_addr = 8'h00;
		bus_wr = 1'b0;
		bus_wdata = 8'h00;
		bus_rd = 1'b0;
	end
	// one write, held up to the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge sys_clk);
		bus_wr = 1'b0;
		bus_wdata = ~d; // released data must not look valid
	endtask
	// one read, answer taken while the valid pulse stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge sys_clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge sys_clk);
		bus_rd = 1'b0;
		d = bus_rdata;
		v = bus_rvalid;
	endtask
endmodule // ccsr_host

// file: sim/ccsr_regs_assertions.sv
// port-level checks for the charger register block
`timescale 1ns/1ps
module ccsr_regs_chk
	import ccsr_pkg::*;
#(
	parameter int SWOFF_DLY_CYCLES = 20, // switch-off delay
	parameter int WD_BASE_CYCLES = 50 // shortest watchdog period
) (
	input wire logic sys_clk, // core clock
	input wire logic srst, // sync reset
	input wire logic [7:0] bus_addr, // offset
	input wire logic bus_wr, // write strobe
	input wire logic [7:0] bus_wdata, // write data
	input wire logic bus_rd, // read strobe
	input wire logic [7:0] bus_rdata, // read data
	input wire logic bus_rvalid, // read valid
	input wire logic defaults_cmd, // defaults command
	input wire logic [1:0] wd_period, // watchdog period
	input wire logic detect_start, // detection start
	input wire logic switch_open, // switch opened
	input wire logic switch_reset_en, // switch reset enable
	input wire logic safety_reset, // safety timer reset
	input wire logic defaults_done, // defaults done
	input wire logic wd_expired // watchdog expiry
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// a control write that no defaults command overrides
	wire ctl_wr = bus_wr && bus_addr == CCSR_OFS_CTRL && !defaults_cmd;
	sequence s_detect_go;
		ctl_wr && bus_wdata[CCSR_B_DETECT];
	endsequence
	sequence s_open_later;
		ctl_wr && bus_wdata[CCSR_B_SWOFF] && bus_wdata[CCSR_B_SWDLY] && !switch_open;
	endsequence
	a_detect_pulse: assert property (s_detect_go |=> detect_start)
		else $error("detect start missing");
	a_reset_en_track: assert property (ctl_wr |=> ##1 switch_reset_en == $past(bus_wdata[2], 2))
		else $error("switch reset enable wrong");
	a_switch_now: assert property (ctl_wr && bus_wdata[5] && !bus_wdata[3] |-> ##2 switch_open)
		else $error("switch not opened at once");
	a_switch_waits: assert property (s_open_later |=> !switch_open [*8])
		else $error("switch opened too early");
	a_rd_answer: assert property (bus_rd |=> bus_rvalid)
		else $error("read not answered");
	a_rvalid_cause: assert property (bus_rvalid |-> $past(bus_rd))
		else $error("valid without read");
	a_rdata_hold: assert property (!$past(bus_rd) |-> $stable(bus_rdata))
		else $error("read data moved");
	a_defaults_pulse: assert property (defaults_cmd |=> defaults_done && safety_reset && !switch_open)
		else $error("defaults command not honoured");
	a_wd_cause: assert property (wd_expired |-> $past(wd_period) != 2'h0 ##1 !wd_expired)
		else $error("watchdog pulse wrong");
endmodule // ccsr_regs_chk
bind ccsr_regs ccsr_regs_chk #(.SWOFF_DLY_CYCLES(SWOFF_DLY_CYCLES),
	.WD_BASE_CYCLES(WD_BASE_CYCLES)) chk_i (.*);

// file: sim/ccsr_regs_tb.sv
// self-checking bench for the charger register block
`timescale 1ns/1ps
module ccsr_regs_tb;
	import ccsr_pkg::*;
	logic sys_clk = 0, srst = 1, defaults_cmd = 0, detect_done = 0, psel_pin = 0;
	logic vbus_present = 1, otg_active = 0, boost_mode = 0, in_vlimit = 0, in_ilimit = 0;
	logic thermal_reg = 0, safety_tick_in = 0, charging = 0, precharge = 0, terminated = 0;
	logic power_good = 0, below_min_sys = 0, boost_fault = 0, input_fault = 0, bat_ovp = 0;
	logic thermal_shutdown = 0, safety_expired = 0;
	logic [1:0] wd_period = 2'h0;
	logic [2:0] detected_type = 3'h0;
	logic [13:0] charge_voltage_target_mv = 14'd4208, input_voltage_limit_mv = 14'd4500, vbat_mv = 14'd4300;
	ccsr_zone_e zone = ZONE_NORMAL;
	logic [7:0] bus_addr, bus_wdata, bus_rdata;
	logic bus_wr, bus_rd, bus_rvalid, detect_start, switch_open, switch_reset_en;
	logic safety_tick, safety_reset, defaults_done, wd_expired;
	logic [13:0] vchg_target, vin_limit;
	int err_count = 0, checked = 0, cycles = 0, ticks = 0;
	ccsr_regs #(.SWOFF_DLY_CYCLES(20), .WD_BASE_CYCLES(50)) ccsr_regs_i (.*);
	ccsr_host ccsr_host_i (.*);
	always #50 sys_clk = ~sys_clk;
	// tick counter and hang guard
	always @(posedge sys_clk) begin
		ticks <= ticks + int'(safety_tick);
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	// read a byte and compare valid flag and data together
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		ccsr_host_i.rd(a, d, v);
		chk(n, {8'h01, e}, {7'h0, v, d});
	endtask
	task automatic t_detect;
		ccsr_host_i.wr(CCSR_OFS_CTRL, 8'hcc);
		chk("detect start", 16'h1, {15'h0, detect_start});
		rchk("ctrl busy", CCSR_OFS_CTRL, 8'hcc);
		@(negedge sys_clk) detect_done = 1'b1;
		@(negedge sys_clk) detect_done = 1'b0;
		rchk("ctrl idle", CCSR_OFS_CTRL, 8'h4c);
	endtask
	task automatic t_status;
		ccsr_host_i.wr(CCSR_OFS_STAT, 8'hff);
		for (int k = 0; k < 8; k++) begin
			if (k == 4) continue;
			vbus_present = k != 0;
			otg_active = k == 7;
			detected_type = 3'(k);
			terminated = k[1:0] == 2'h3;
			charging = k[1:0] != 2'h0;
			precharge = k[1:0] == 2'h1;
			{below_min_sys, thermal_reg, power_good} = {k[0], k[1], k[2]};
			rchk("status", CCSR_OFS_STAT, {3'(k), 2'(k), k[2:0]});
		end
		{otg_active, thermal_reg, charging, terminated} = 4'h0;
	endtask
	task automatic t_fault;
		logic [2:0] zc [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};
		logic [1:0] cf [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
		ccsr_host_i.wr(CCSR_OFS_FAULT, 8'hff);
		for (int b = 0; b < 2; b++) begin
			for (int z = 0; z < 5; z++) begin
				boost_mode = b[0];
				boost_fault = b[0];
				zone = ccsr_zone_e'(z);
				{input_fault, thermal_shutdown, safety_expired} = {z == 1, z inside {1, 2}, z > 0};
				bat_ovp = z[0];
				rchk("fault", CCSR_OFS_FAULT, {1'b0, b[0], cf[z], z[0],
					(b == 1 && z inside {1, 2}) ? 3'h0 : zc[z]});
			end
		end
		{boost_mode, boost_fault, input_fault, thermal_shutdown, safety_expired, bat_ovp} = 6'h0;
	endtask
	task automatic t_volt;
		logic [13:0] off [4] = '{14'd0, 14'd200, 14'd250, 14'd300};
		zone = ZONE_WARM;
		for (int t = 0; t < 4; t++) begin
			ccsr_host_i.wr(CCSR_OFS_CTRL, 8'h44 | 8'(t));
			@(negedge sys_clk);
			chk("vin limit", (t > 0 && 4300 + off[t] > 4500) ? 4300 + off[t] : 4500, vin_limit);
			chk("warm cap", 16'd4100, vchg_target);
		end
		ccsr_host_i.wr(CCSR_OFS_CTRL, 8'h54);
		@(negedge sys_clk);
		chk("warm full", 16'd4208, vchg_target);
		zone = ZONE_NORMAL;
	endtask
	task automatic t_switch;
		int n;
		ccsr_host_i.wr(CCSR_OFS_CTRL, 8'h6c);
		for (n = 0; n < 40 && !switch_open; n++) @(negedge sys_clk);
		chk("switch delay", 16'h1, {15'h0, n >= 18 && n <= 24});
		ccsr_host_i.wr(CCSR_OFS_CTRL, 8'h4c);
		@(negedge sys_clk);
		chk("switch closed", 16'h0, {15'h0, switch_open});
		ccsr_host_i.wr(CCSR_OFS_CTRL, 8'h64);
		@(negedge sys_clk);
		chk("switch at once", 16'h1, {15'h0, switch_open});
		@(negedge sys_clk) defaults_cmd = 1'b1;
		@(negedge sys_clk) defaults_cmd = 1'b0;
		chk("defaults", 16'h3, {14'h0, defaults_done, safety_reset});
		chk("defaults switch", 16'h0, {15'h0, switch_open});
		rchk("ctrl defaults", CCSR_OFS_CTRL, CCSR_CTRL_RST);
	endtask
	task automatic t_tick(input logic [2:0] why, input int e);
		{in_vlimit, in_ilimit, thermal_reg} = why; // each cause alone slows the timer
		ticks = 0;
		repeat (4) begin
			@(negedge sys_clk) safety_tick_in = 1'b1;
			@(negedge sys_clk) safety_tick_in = 1'b0;
			repeat (3) @(negedge sys_clk);
		end
		chk("safety ticks", 16'(e), 16'(ticks));
	endtask
	task automatic t_watchdog;
		int n;
		ccsr_host_i.wr(CCSR_OFS_CTRL, 8'h3b);
		wd_period = 2'h1;
		for (n = 0; n < 200 && !wd_expired; n++) @(negedge sys_clk);
		chk("wd period", 16'h1, {15'h0, n >= 45 && n <= 55});
		wd_period = 2'h0;
		rchk("ctrl after wd", CCSR_OFS_CTRL, 8'h6f);
		rchk("wd fault", CCSR_OFS_FAULT, 8'h80);
		rchk("wd fault clr", CCSR_OFS_FAULT, 8'h00);
	endtask
	task automatic complete_run;
		if (err_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(negedge sys_clk);
		srst = 1'b0;
		rchk("ctrl reset", CCSR_OFS_CTRL, CCSR_CTRL_RST);
		chk("reset enable", 16'h1, {15'h0, switch_reset_en});
		rchk("unmapped", 8'h0a, 8'h00);
		t_detect();
		t_status();
		t_fault();
		t_volt();
		t_switch();
		t_tick(3'h4, 2);
		t_tick(3'h2, 2);
		t_tick(3'h1, 2);
		t_tick(3'h0, 4);
		t_watchdog();
		complete_run();
	end
endmodule // ccsr_regs_tb
